// >>> src/simap_defs.svh
/*
 Offsets, fields, resets and timing of the function mapper.
 Assumes a 250 MHz pclk.
*/
// What this block does
// [RQ1] Every function sits in one of three classes
// [RQ2] Single-input functions refused on several inputs
// [RQ3] Inhibit holds the power stage off
// [RQ4] External reset clears faults and reinitialises
// [RQ5] Limits block only their own direction
// [RQ6] Fault input disables the drive
// [RQ7] Emergency stop forces speed command zero
// [RQ8] Stop/go decelerates to configured speed
// [RQ9] Aux encoder fault input flags encoder fault
// [RQ10] Operation control input selects control mode
// [RQ11] Four inputs form a 4-bit profile index
// [RQ12] Start trigger runs the selected profile
// [RQ13] Set home zeroes the encoder count
// [RQ14] Pulse/direction used paired, pulse position mode only
// [RQ15] Up/down pair counts position, position mode only
// [RQ16] Encoder output divides by 1, 2, 4, 8
// [RQ17] Resolver or sin/cos synthesises encoder outputs
// [RQ18] Two analog commands captured as 16 bits
// [RQ19] Two 12-bit monitors refreshed each servo tick
// [RQ20] Monitor invalid until power-on reset done
// [RQ21] Monitor disabled during parameter save/recall
// [RQ22] Unmapped functions stay inactive
// [RQ23] Over-temperature input, polarity set, latches fault
`ifndef SIMAP_DEFS_SVH
`define SIMAP_DEFS_SVH

// --------------------
// Register offsets
// --------------------
`define SIMAP_OFS_CTRL 12'h000
`define SIMAP_OFS_STATUS 12'h004
`define SIMAP_OFS_IN_POL 12'h008
`define SIMAP_OFS_SPEED 12'h00c
`define SIMAP_OFS_MON_SEL 12'h010
`define SIMAP_OFS_CMD_POS 12'h014
`define SIMAP_OFS_ENC_POS 12'h018
`define SIMAP_OFS_ADC 12'h01c
`define SIMAP_OFS_MAP_BASE 12'h040

// --------------------
// Field positions
// --------------------
`define SIMAP_CTRL_BASE_MODE 1:0
`define SIMAP_CTRL_ALT_MODE 3:2
`define SIMAP_CTRL_FB_SYNTH 4
`define SIMAP_CTRL_OVT_POL 5
`define SIMAP_CTRL_DIV_SEL 7:6
`define SIMAP_CTRL_UPDN 8
`define SIMAP_ST_FAULT 0
`define SIMAP_ST_OVT 1
`define SIMAP_ST_ENC 2
`define SIMAP_ST_MAP_ERR 3

// --------------------
// Reset values
// --------------------
`define SIMAP_CTRL_RST 32'h0000_0001
`define SIMAP_SPEED_RST 32'h0000_0000
`define SIMAP_MON_MID 12'h800
`define SIMAP_SPECIFIC_MASK 13'h1800

// --------------------
// Timing
// --------------------
`define SIMAP_CLK_NS 4
`define SIMAP_RST_HOLD_NS 1000
`define SIMAP_RST_HOLD_CYC ((`SIMAP_RST_HOLD_NS + `SIMAP_CLK_NS - 1) / `SIMAP_CLK_NS)

`endif

// >>> src/simap_pkg.sv
/*
 Types of the function mapper. Numbers sit in simap_defs.svh.
*/
package simap_pkg;

   typedef enum logic [1:0] {
      SIMAP_MODE_CURRENT = 2'h0,
      SIMAP_MODE_VELOCITY = 2'h1,
      SIMAP_MODE_POSITION = 2'h2
   } simap_mode_t;

   typedef enum logic [4:0] {
      SIMAP_F_INHIBIT = 5'h00, SIMAP_F_RESET = 5'h01, SIMAP_F_POS_LIM = 5'h02,
      SIMAP_F_NEG_LIM = 5'h03, SIMAP_F_FAULT = 5'h04, SIMAP_F_STOP_GO = 5'h05,
      SIMAP_F_ESTOP = 5'h06, SIMAP_F_AUX_ENC = 5'h07, SIMAP_F_OP_MODE = 5'h08,
      SIMAP_F_PROF_START = 5'h09, SIMAP_F_STEP_STOP = 5'h0a, SIMAP_F_SET_HOME = 5'h0b,
      SIMAP_F_PROF_B0 = 5'h0c, SIMAP_F_PROF_B3 = 5'h0f, SIMAP_F_PULSE = 5'h10,
      SIMAP_F_DIR = 5'h11, SIMAP_F_UP = 5'h12, SIMAP_F_DOWN = 5'h13
   } simap_func_t;

   typedef enum logic [1:0] {
      SIMAP_CLS_MULTI = 2'h0,
      SIMAP_CLS_SINGLE = 2'h1,
      SIMAP_CLS_SPECIFIC = 2'h2
   } simap_cls_t;

   // Gray steps idle -> hold -> init; init -> idle flips both bits
   typedef enum logic [1:0] {
      SIMAP_RS_IDLE = 2'b00,
      SIMAP_RS_HOLD = 2'b01,
      SIMAP_RS_INIT = 2'b11
   } simap_rst_st_t;

   typedef struct packed {
      logic pwr_en;
      logic pos_block;
      logic neg_block;
      logic hw_fault;
      logic enc_fault;
      logic ovt_fault;
      logic stopping;
      logic dsp_reset;
      logic drive_init;
      logic step_stop;
   } simap_drv_t;

   typedef struct packed {
      logic start;
      logic [3:0] index;
   } simap_prof_t;

   typedef struct packed {
      logic valid;
      logic [11:0] code0;
      logic [11:0] code1;
   } simap_mon_t;

endpackage

// >>> src/simap_enc_div.sv
/*
 Encoder output divider, one quadrature edge per 1, 2, 4 or 8 counts.
 Assumes one-cycle step pulses.
*/
`timescale 1ns/1ps
`include "simap_defs.svh"
module simap_enc_div (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic step,
   input wire logic dir_up,
   input wire logic [1:0] div_sel,
   output logic qa_r,
   output logic qb_r
);
   logic [2:0] sub_r;
   logic [1:0] phase_r;
   logic [2:0] top;

   assign top = 3'((4'h1 << div_sel) - 4'h1);

   // --------------------
   // Sub-count and phase
   // --------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_r <= 3'h0;
         phase_r <= 2'h0;
      end else if (step) begin // see [RQ16]
         if (dir_up) begin
            if (sub_r >= top) begin
               sub_r <= 3'h0;
               phase_r <= phase_r + 2'h1;
            end else begin
               sub_r <= sub_r + 3'h1;
            end
         end else begin
            if (sub_r == 3'h0) begin
               sub_r <= top;
               phase_r <= phase_r - 2'h1;
            end else begin
               sub_r <= sub_r - 3'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qa_r <= 1'b0;
         qb_r <= 1'b0;
      end else begin
         qa_r <= phase_r[1];
         qb_r <= phase_r[1] ^ phase_r[0];
      end
   end
endmodule // simap_enc_div

// >>> src/simap_top.sv
/*
 Servo input function mapper with APB registers.
 Assumes inputs synchronous to pclk,
 one-cycle strobes and an APB master.
*/
`timescale 1ns/1ps
`include "simap_defs.svh"
module simap_top #(
   parameter int NUM_IN = 13,
   parameter int NUM_FN = 20,
   parameter logic [12:0] SPECIFIC_MASK = `SIMAP_SPECIFIC_MASK,
   parameter int RST_HOLD_CYC = `SIMAP_RST_HOLD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   input wire logic [NUM_IN-1:0] din,
   input wire logic ovt_pin,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic synth_step,
   input wire logic synth_dir_up,
   input wire logic [15:0] adc0_data,
   input wire logic [15:0] adc1_data,
   input wire logic adc_strobe,
   input wire logic servo_tick,
   input wire logic por_done,
   input wire logic nvm_busy,
   output simap_pkg::simap_drv_t drv_r,
   output simap_pkg::simap_prof_t prof_r,
   output simap_pkg::simap_mode_t mode_r,
   output logic signed [15:0] speed_cmd_r,
   output simap_pkg::simap_mon_t mon_r,
   output logic enc_out_a_r,
   output logic enc_out_b_r
);
   logic [31:0] ctrl_r;
   logic [NUM_IN-1:0] in_pol_r;
   logic [31:0] speed_r;
   logic [6:0] mon_sel_r;
   logic [NUM_IN-1:0] map_r [NUM_FN];
   logic [NUM_IN-1:0] din_r;
   logic [NUM_FN-1:0] fn_act;
   logic [NUM_FN-1:0] fn_prev_r;
   logic [NUM_FN-1:0] fn_rise;
   logic fault_r, ovt_r, enc_flt_r, map_err_r;
   logic signed [31:0] cmd_pos_r, enc_pos_r;
   logic [15:0] adc0_r, adc1_r;
   logic [1:0] quad_prev_r;
   logic quad_step, quad_up, fb_step, fb_up;
   logic pulse_ok, updn_ok, pos_mode;
   logic ext_reset;
   simap_pkg::simap_rst_st_t rst_st_r;
   logic [15:0] rst_cnt_r;
   logic setup, access_wr, map_hit, map_ok;
   logic [4:0] map_idx;
   logic [31:0] rd_val;
   logic rd_err;
   logic signed [15:0] speed_pick;
   logic [15:0] status_clr;

   // --------------------
   // Helpers
   // --------------------
   function automatic simap_pkg::simap_cls_t func_class(input logic [4:0] f);
      if (f <= 5'(simap_pkg::SIMAP_F_OP_MODE)) // see [RQ1]
         return simap_pkg::SIMAP_CLS_MULTI;
      else if (f <= 5'(simap_pkg::SIMAP_F_PROF_B3))
         return simap_pkg::SIMAP_CLS_SINGLE;
      else
         return simap_pkg::SIMAP_CLS_SPECIFIC;
   endfunction

   // Mask obeys the class of f
   function automatic logic map_legal(input logic [4:0] f, input logic [NUM_IN-1:0] m);
      logic [NUM_IN-1:0] low;
      low = m & (m - NUM_IN'(1));
      case (func_class(f))
         simap_pkg::SIMAP_CLS_SINGLE: map_legal = (low == '0); // see [RQ2]
         simap_pkg::SIMAP_CLS_SPECIFIC: map_legal = ((m & ~SPECIFIC_MASK) == '0); // see [RQ1]
         default: map_legal = 1'b1;
      endcase
   endfunction

   function automatic logic [11:0] mon_pick(input logic [2:0] s, input logic [15:0] spd,
                                             input logic [31:0] cp, input logic [31:0] ep,
                                             input logic [15:0] a0, input logic [15:0] a1);
      case (s)
         3'h0: mon_pick = spd[15:4];
         3'h1: mon_pick = cp[15:4];
         3'h2: mon_pick = ep[15:4];
         3'h3: mon_pick = a0[15:4];
         3'h4: mon_pick = a1[15:4];
         default: mon_pick = `SIMAP_MON_MID;
      endcase
   endfunction

   // --------------------
   // APB decode
   // --------------------
   assign setup = psel && !penable;
   assign access_wr = psel && penable && pready_r && pwrite;
   assign map_idx = 5'(paddr[11:2] - 10'(`SIMAP_OFS_MAP_BASE >> 2));
   assign map_hit = (paddr >= `SIMAP_OFS_MAP_BASE)
                    && (paddr < 12'(`SIMAP_OFS_MAP_BASE + 4 * NUM_FN))
                    && (paddr[1:0] == 2'h0);
   assign map_ok = map_legal(map_idx, pwdata[NUM_IN-1:0]);

   always_comb begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      if (map_hit) begin
         rd_val = 32'(map_r[map_idx]);
         rd_err = pwrite && !map_ok;
      end else begin
         case (paddr)
            `SIMAP_OFS_CTRL: rd_val = ctrl_r;
            `SIMAP_OFS_STATUS: rd_val = {28'h0, map_err_r, enc_flt_r, ovt_r, fault_r};
            `SIMAP_OFS_IN_POL: rd_val = 32'(in_pol_r);
            `SIMAP_OFS_SPEED: rd_val = speed_r;
            `SIMAP_OFS_MON_SEL: rd_val = {25'h0, mon_sel_r};
            `SIMAP_OFS_CMD_POS: rd_val = cmd_pos_r;
            `SIMAP_OFS_ENC_POS: rd_val = enc_pos_r;
            `SIMAP_OFS_ADC: rd_val = {adc1_r, adc0_r};
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Answer is prepared in setup so every APB output stays a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         if (setup) begin
            prdata_r <= pwrite ? 32'h0 : rd_val;
            pslverr_r <= rd_err;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `SIMAP_CTRL_RST;
         in_pol_r <= '0;
         speed_r <= `SIMAP_SPEED_RST;
         mon_sel_r <= 7'h0;
      end else if (access_wr && !pslverr_r) begin
         case (paddr)
            `SIMAP_OFS_CTRL: ctrl_r <= {23'h0, pwdata[8:0]};
            `SIMAP_OFS_IN_POL: in_pol_r <= pwdata[NUM_IN-1:0];
            `SIMAP_OFS_SPEED: speed_r <= pwdata;
            `SIMAP_OFS_MON_SEL: mon_sel_r <= pwdata[6:0];
            default: ;
         endcase
      end
   end

   // A refused mapping leaves the old mask in place
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_FN; i++) begin
            map_r[i] <= '0; // see [RQ22]
         end
      end else if (access_wr && map_hit && map_ok) begin // see [RQ2]
         map_r[map_idx] <= pwdata[NUM_IN-1:0];
      end
   end

   // --------------------
   // Function levels
   // --------------------
   always_comb begin
      for (int f = 0; f < NUM_FN; f++) begin
         fn_act[f] = |((din_r ^ in_pol_r) & map_r[f]); // see [RQ22]
      end
   end
   assign fn_rise = fn_act & ~fn_prev_r;
   assign ext_reset = fn_rise[simap_pkg::SIMAP_F_RESET];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_r <= '0;
         fn_prev_r <= '0;
      end else begin
         din_r <= din;
         fn_prev_r <= fn_act;
      end
   end

   // --------------------
   // Latched faults
   // --------------------
   // W1C clear; a fresh event wins
   assign status_clr = (access_wr && !pslverr_r && paddr == `SIMAP_OFS_STATUS) ?
                       pwdata[15:0] : 16'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_r <= 1'b0;
         ovt_r <= 1'b0;
         enc_flt_r <= 1'b0;
         map_err_r <= 1'b0;
      end else begin
         if (fn_act[simap_pkg::SIMAP_F_FAULT]) // see [RQ6]
            fault_r <= 1'b1;
         else if (ext_reset || status_clr[`SIMAP_ST_FAULT]) // see [RQ4]
            fault_r <= 1'b0;
         if (ovt_pin == ctrl_r[`SIMAP_CTRL_OVT_POL]) // see [RQ23]
            ovt_r <= 1'b1;
         else if (ext_reset || status_clr[`SIMAP_ST_OVT])
            ovt_r <= 1'b0;
         if (fn_act[simap_pkg::SIMAP_F_AUX_ENC]) // see [RQ9]
            enc_flt_r <= 1'b1;
         else if (ext_reset || status_clr[`SIMAP_ST_ENC])
            enc_flt_r <= 1'b0;
         if (access_wr && map_hit && !map_ok)
            map_err_r <= 1'b1;
         else if (status_clr[`SIMAP_ST_MAP_ERR])
            map_err_r <= 1'b0;
      end
   end

   // --------------------
   // Reset and reinitialise sequence
   // --------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_st_r <= simap_pkg::SIMAP_RS_IDLE;
         rst_cnt_r <= 16'h0;
      end else begin
         case (rst_st_r)
            simap_pkg::SIMAP_RS_IDLE: begin
               if (ext_reset) begin // see [RQ4]
                  rst_st_r <= simap_pkg::SIMAP_RS_HOLD;
                  rst_cnt_r <= 16'(RST_HOLD_CYC - 1);
               end
            end
            simap_pkg::SIMAP_RS_HOLD: begin
               if (rst_cnt_r == 16'h0)
                  rst_st_r <= simap_pkg::SIMAP_RS_INIT;
               else
                  rst_cnt_r <= rst_cnt_r - 16'h1;
            end
            simap_pkg::SIMAP_RS_INIT: rst_st_r <= simap_pkg::SIMAP_RS_IDLE;
            default: rst_st_r <= simap_pkg::SIMAP_RS_IDLE;
         endcase
      end
   end

   // --------------------
   // Drive effects
   // --------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_r <= '0;
         mode_r <= simap_pkg::SIMAP_MODE_CURRENT;
      end else begin
         drv_r.pwr_en <= !fn_act[simap_pkg::SIMAP_F_INHIBIT] && !fault_r && !ovt_r
                         && !fn_act[simap_pkg::SIMAP_F_FAULT]
                         && rst_st_r == simap_pkg::SIMAP_RS_IDLE; // see [RQ3] [RQ6] [RQ23]
         drv_r.pos_block <= fn_act[simap_pkg::SIMAP_F_POS_LIM]; // see [RQ5]
         drv_r.neg_block <= fn_act[simap_pkg::SIMAP_F_NEG_LIM]; // see [RQ5]
         drv_r.hw_fault <= fault_r;
         drv_r.enc_fault <= enc_flt_r;
         drv_r.ovt_fault <= ovt_r;
         drv_r.stopping <= fn_act[simap_pkg::SIMAP_F_STOP_GO]; // see [RQ8]
         drv_r.dsp_reset <= rst_st_r == simap_pkg::SIMAP_RS_HOLD; // see [RQ4]
         drv_r.drive_init <= rst_st_r == simap_pkg::SIMAP_RS_INIT; // see [RQ4]
         drv_r.step_stop <= fn_rise[simap_pkg::SIMAP_F_STEP_STOP];
         if (fn_act[simap_pkg::SIMAP_F_OP_MODE]) // see [RQ10]
            mode_r <= simap_pkg::simap_mode_t'(ctrl_r[`SIMAP_CTRL_ALT_MODE]);
         else
            mode_r <= simap_pkg::simap_mode_t'(ctrl_r[`SIMAP_CTRL_BASE_MODE]);
      end
   end

   // Estop outranks stop/go; limits then cut only the blocked sign
   always_comb begin
      if (fn_act[simap_pkg::SIMAP_F_ESTOP]) // see [RQ7]
         speed_pick = 16'sh0;
      else if (fn_act[simap_pkg::SIMAP_F_STOP_GO]) // see [RQ8]
         speed_pick = signed'(speed_r[31:16]);
      else
         speed_pick = signed'(speed_r[15:0]);
      if (fn_act[simap_pkg::SIMAP_F_POS_LIM] && speed_pick > 16'sh0) // see [RQ5]
         speed_pick = 16'sh0;
      if (fn_act[simap_pkg::SIMAP_F_NEG_LIM] && speed_pick < 16'sh0) // see [RQ5]
         speed_pick = 16'sh0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         speed_cmd_r <= 16'sh0;
      else
         speed_cmd_r <= speed_pick;
   end

   // --------------------
   // Profile selection
   // --------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prof_r <= '0;
      end else begin
         prof_r.start <= fn_rise[simap_pkg::SIMAP_F_PROF_START]; // see [RQ12]
         prof_r.index <= fn_act[simap_pkg::SIMAP_F_PROF_B3:simap_pkg::SIMAP_F_PROF_B0]; // see [RQ11]
      end
   end

   // --------------------
   // Commanded position
   // --------------------
   assign pos_mode = mode_r == simap_pkg::SIMAP_MODE_POSITION;
   assign pulse_ok = pos_mode && !ctrl_r[`SIMAP_CTRL_UPDN]
                     && |map_r[simap_pkg::SIMAP_F_PULSE]
                     && |map_r[simap_pkg::SIMAP_F_DIR]; // see [RQ14]
   assign updn_ok = pos_mode && ctrl_r[`SIMAP_CTRL_UPDN]
                    && |map_r[simap_pkg::SIMAP_F_UP]
                    && |map_r[simap_pkg::SIMAP_F_DOWN]; // see [RQ15]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_pos_r <= 32'sh0;
      end else if (pulse_ok && fn_rise[simap_pkg::SIMAP_F_PULSE]) begin // see [RQ14]
         cmd_pos_r <= fn_act[simap_pkg::SIMAP_F_DIR] ? cmd_pos_r + 32'sh1 : cmd_pos_r - 32'sh1;
      end else if (updn_ok) begin // see [RQ15]
         if (fn_rise[simap_pkg::SIMAP_F_UP] && !fn_rise[simap_pkg::SIMAP_F_DOWN])
            cmd_pos_r <= cmd_pos_r + 32'sh1;
         else if (fn_rise[simap_pkg::SIMAP_F_DOWN] && !fn_rise[simap_pkg::SIMAP_F_UP])
            cmd_pos_r <= cmd_pos_r - 32'sh1;
      end
   end

   // --------------------
   // Encoder count and output
   // --------------------
   assign quad_step = {enc_a, enc_b} != quad_prev_r;
   assign quad_up = quad_prev_r[1] ^ enc_b;
   assign fb_step = ctrl_r[`SIMAP_CTRL_FB_SYNTH] ? synth_step : quad_step; // see [RQ17]
   assign fb_up = ctrl_r[`SIMAP_CTRL_FB_SYNTH] ? synth_dir_up : quad_up; // see [RQ17]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quad_prev_r <= 2'h0;
         enc_pos_r <= 32'sh0;
      end else begin
         quad_prev_r <= {enc_a, enc_b};
         if (fn_act[simap_pkg::SIMAP_F_SET_HOME]) // see [RQ13]
            enc_pos_r <= 32'sh0;
         else if (fb_step)
            enc_pos_r <= fb_up ? enc_pos_r + 32'sh1 : enc_pos_r - 32'sh1;
      end
   end

   simap_enc_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .step(fb_step),
      .dir_up(fb_up),
      .div_sel(ctrl_r[`SIMAP_CTRL_DIV_SEL]),
      .qa_r(enc_out_a_r),
      .qb_r(enc_out_b_r)
   ); // see [RQ16] [RQ17]

   // --------------------
   // Analog capture and monitors
   // --------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc0_r <= 16'h0;
         adc1_r <= 16'h0;
      end else if (adc_strobe) begin // see [RQ18]
         adc0_r <= adc0_data;
         adc1_r <= adc1_data;
      end
   end

   // Codes park at midscale (0 V) while invalid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon_r <= {1'b0, `SIMAP_MON_MID, `SIMAP_MON_MID};
      end else if (!por_done || nvm_busy) begin // see [RQ20] [RQ21]
         mon_r <= {1'b0, `SIMAP_MON_MID, `SIMAP_MON_MID};
      end else if (servo_tick) begin // see [RQ19]
         mon_r.valid <= 1'b1;
         mon_r.code0 <= mon_pick(mon_sel_r[2:0], speed_cmd_r, cmd_pos_r, enc_pos_r,
                                 adc0_r, adc1_r);
         mon_r.code1 <= mon_pick(mon_sel_r[6:4], speed_cmd_r, cmd_pos_r, enc_pos_r,
                                 adc0_r, adc1_r);
      end
   end
endmodule // simap_top

// >>> verif/simap_chk.sv
/* Port checker of simap_top.
 Assumes one pclk domain and presetn low-active. */
`timescale 1ns/1ps
module simap_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready_r,
   input wire logic por_done,
   input wire logic nvm_busy,
   input simap_pkg::simap_drv_t drv_r,
   input simap_pkg::simap_prof_t prof_r,
   input logic signed [15:0] speed_cmd_r,
   input simap_pkg::simap_mon_t mon_r
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready_r; endproperty
   a_rdy: assert property (p_rdy)
      else $error("no ready after setup");
   property p_inv; !por_done [*2] |-> !mon_r.valid && mon_r.code0 == 12'h800; endproperty
   a_inv: assert property (p_inv)
      else $error("monitor valid before power-on done");
   property p_nvm; nvm_busy [*2] |-> !mon_r.valid; endproperty
   a_nvm: assert property (p_nvm)
      else $error("monitor valid during save");
   property p_dsp; drv_r.dsp_reset |-> !drv_r.pwr_en; endproperty
   a_dsp: assert property (p_dsp)
      else $error("power on during reset hold");
   property p_init; drv_r.drive_init |=> !drv_r.drive_init && !drv_r.dsp_reset; endproperty
   a_init: assert property (p_init)
      else $error("init not a single pulse");
   property p_ovt; $past(drv_r.ovt_fault) && drv_r.ovt_fault |-> !drv_r.pwr_en; endproperty
   a_ovt: assert property (p_ovt)
      else $error("power on with over-temp");
   property p_hw; $past(drv_r.hw_fault) && drv_r.hw_fault |-> !drv_r.pwr_en; endproperty
   a_hw: assert property (p_hw)
      else $error("power on with fault");
   property p_lim; drv_r.pos_block |-> speed_cmd_r <= 16'sh0; endproperty
   a_lim: assert property (p_lim)
      else $error("positive speed while blocked");
   property p_start; prof_r.start |=> !prof_r.start; endproperty
   a_start: assert property (p_start)
      else $error("start longer than a pulse");
   c_start: cover property (prof_r.start);
   c_dsp: cover property (drv_r.dsp_reset);
   c_mon: cover property (mon_r.valid);
endmodule // simap_chk
bind simap_top simap_chk simap_chk_inst (.*);

// >>> verif/simap_ctl_model.sv
/* Far-side controller on the input terminals.
 Assumes levels set after a pclk edge. */
`timescale 1ns/1ps
module simap_ctl_model (
   input wire logic pclk,
   input wire logic slow,
   input wire logic [12:0] want,
   output logic [12:0] din
);
   logic [12:0] late_r;
   initial din = 13'h0;
   // Slow mode lags a cycle
   always @(posedge pclk) begin
      late_r <= want;
      din <= slow ? late_r : want;
   end
endmodule // simap_ctl_model

// >>> verif/test_servo_io_function_mapper.sv
/* Bench of simap_top with a controller model.
 Assumes the package and checker compiled first. */
`timescale 1ns/1ps
module test_servo_io_function_mapper;
   logic pclk = 0, presetn, psel, penable, pwrite, pready_r, pslverr_r, slow;
   logic adc_strobe, servo_tick, por_done, nvm_busy, ovt_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_r, s;
   logic [12:0] din, want;
   logic [15:0] adc0_data, adc1_data;
   logic [3:0] idx;
   simap_pkg::simap_drv_t drv_r;
   simap_pkg::simap_prof_t prof_r;
   simap_pkg::simap_mode_t mode_r;
   simap_pkg::simap_mon_t mon_r;
   logic signed [15:0] speed_cmd_r;
   int failures = 0, total_checks = 0, n, k2, got;
   simap_top #(.RST_HOLD_CYC(4)) simap_top_inst (.*, .enc_out_a_r(), .enc_out_b_r(),
      .enc_a(1'b0), .enc_b(1'b0), .synth_step(1'b0), .synth_dir_up(1'b0));
   simap_ctl_model simap_ctl_model_inst (.pclk(pclk), .slow(slow), .want(want), .din(din));
   always #2 pclk = ~pclk;
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] v, input logic [31:0] e);
      total_checks++;
      if (v !== e) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, v, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e,
         input logic err);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready_r !== 1'b1);
      chk(pslverr_r, err);
      if (!w) chk(prdata_r, e);
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   // Speed model: estop, stop/go, run, limits
   function automatic int spd(logic [31:0] v, logic [3:0] r);
      int q;
      q = r[3] ? 0 : r[2] ? int'($signed(v[31:16])) : int'($signed(v[15:0]));
      if ((r[0] && q > 0) || (r[1] && q < 0)) q = 0;
      return q;
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      final_report;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, slow, adc_strobe, servo_tick, nvm_busy, por_done} = 0;
      paddr = 0; pwdata = 0; want = 0; ovt_pin = 1; adc0_data = 0; adc1_data = 0;
      presetn = 0;
      void'($urandom(32'h77fce453));
      cyc(3); presetn <= 1; want <= 13'($urandom); cyc(5);
      apb(0, 12'h000, 0, 32'h1, 0);
      apb(0, 12'h020, 0, 32'h0, 1);
      chk(drv_r.pwr_en, 1);
      apb(1, 12'h064, 32'h3, 0, 1);
      apb(1, 12'h080, 32'h1, 0, 1);
      apb(0, 12'h004, 0, 32'h8, 0);
      $display("test maps done");
      want <= 0;
      apb(1, 12'h040, 32'h1, 0, 0);
      apb(1, 12'h050, 32'h2, 0, 0);
      for (int i = 0; i < 2; i++) begin
         want <= 13'(1 << i); cyc(5);
         chk(drv_r.pwr_en, 0);
         want <= 0; cyc(3); apb(1, 12'h004, 32'hf, 0, 0); cyc(5);
         chk(drv_r.pwr_en, 1);
      end
      $display("test disable done");
      for (int b = 0; b < 4; b++) apb(1, 12'h048 + 12'(4 * (b + b / 2)), 32'(4 << b), 0, 0);
      for (int k = 0; k < 16; k++) begin
         s = $urandom;
         apb(1, 12'h00c, s, 0, 0);
         want <= 13'(k << 2); cyc(5);
         chk(32'(speed_cmd_r), 32'(spd(s, 4'(k))));
      end
      $display("test speed done");
      apb(1, 12'h060, 32'h40, 0, 0);
      for (int m = 0; m < 3; m++) begin
         apb(1, 12'h000, 32'(m * 4 + 2 - m), 0, 0);
         for (int a = 0; a < 2; a++) begin
            want <= 13'(a << 6); cyc(5);
            chk(32'(mode_r), 32'(a ? m : 2 - m));
         end
      end
      $display("test mode done");
      for (int b = 0; b < 4; b++) apb(1, 12'h070 + 12'(4 * b), 32'(1 << (7 + b)), 0, 0);
      apb(1, 12'h064, 32'h800, 0, 0);
      slow <= 1;
      for (int j = 0; j < 4; j++) begin
         idx = 4'($urandom); got = 0;
         want <= 13'(idx << 7); cyc(5);
         want <= 13'(idx << 7) | 13'h800;
         repeat (8) begin
            @(posedge pclk);
            if (prof_r.start === 1'b1) begin
               got++;
               chk(prof_r.index, idx);
            end
         end
         chk(got, 1);
      end
      $display("test profile done");
      apb(1, 12'h044, 32'h1000, 0, 0);
      want <= 13'h2; cyc(5); want <= 13'h1000; n = 0; k2 = 0;
      repeat (40) begin
         @(posedge pclk);
         n += drv_r.dsp_reset;
         k2 += drv_r.drive_init;
      end
      chk(n, 4);
      chk(k2, 1);
      chk(drv_r.pwr_en, 1);
      $display("test reset done");
      apb(1, 12'h010, 32'h43, 0, 0);
      for (int p = 0; p < 3; p++) begin
         por_done <= p > 0; nvm_busy <= p > 1; adc_strobe <= 1;
         adc0_data <= 16'($urandom); adc1_data <= 16'($urandom);
         cyc(1); adc_strobe <= 0; servo_tick <= 1; cyc(1); servo_tick <= 0; cyc(3);
         chk({mon_r.valid, mon_r.code0, mon_r.code1}, p == 1 ?
            {1'b1, adc0_data[15:4], adc1_data[15:4]} : {1'b0, 24'h800800});
      end
      apb(0, 12'h01c, 0, {adc1_data, adc0_data}, 0);
      $display("test monitor done");
      want <= 0;
      apb(1, 12'h000, 32'h102, 0, 0);
      apb(1, 12'h088, 32'h800, 0, 0);
      apb(1, 12'h08c, 32'h1000, 0, 0);
      repeat (3) begin
         want <= 13'h800; cyc(4); want <= 0; cyc(4);
      end
      want <= 13'h1000; cyc(4); want <= 0; cyc(4);
      apb(0, 12'h014, 0, 32'h2, 0);
      apb(1, 12'h000, 32'h2, 0, 0);
      apb(1, 12'h080, 32'h800, 0, 0);
      apb(1, 12'h084, 32'h1000, 0, 0);
      want <= 13'h1000; cyc(4); want <= 13'h1800; cyc(4); want <= 13'h1000; cyc(4);
      apb(0, 12'h014, 0, 32'h3, 0);
      $display("test position done");
      final_report;
   end
endmodule // test_servo_io_function_mapper
